/* File: hw/lhp_host_port.sv */
// What this block does
// - Strap high selects the parallel bus, strap low selects serial input.
// - Parallel mode moves bytes over an eight-line bidirectional bus.
// - Serial data on top line, clock on next, six lower lines released.
// - Chip select inactive releases all eight data lines.
// - Selected only while low-active select low and high-active select high.
// - Data/command select high means data or parameter, low means command.
// - Serial bytes are also classified by the data/command select line.
// - Reset input low initialises the port, acting on level.
// - Family strap high picks enable-clock style, low picks separate strobes.
// - Strobe style drives the bus while the read strobe is low.
// - Strobe style captures the bus on the write strobe leading edge.
// - Enable-clock style uses the read strobe pin as enable clock.
// - Enable-clock style: direction high reads, low writes.
// - Serial mode is write only; no read back.
`timescale 1ns/1ps
module lhp_host_port
  import lhp_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = LHP_FIFO_D
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  RESET_LOW_INPUT_N,
  // Straps
  input  wire logic                  PAR_SERIAL_STRAP,
  input  wire logic                  HOST_FAMILY_STRAP,
  // Bus control pins
  input  wire logic                  CHIP_SELECT_LOW_ACTIVE_N,
  input  wire logic                  CHIP_SELECT_HIGH_ACTIVE,
  input  wire logic                  DATA_COMMAND_SELECT,
  input  wire logic                  RD_N_E,
  input  wire logic                  WR_N_RW,
  // Data pins
  input  wire logic [LHP_DATA_W-1:0] D_IN,
  output logic      [LHP_DATA_W-1:0] D_OUT,
  output logic      [LHP_DATA_W-1:0] D_OE,
  // Received words to the core
  output logic                       RX_VALID,
  input  wire logic                  RX_READY,
  output logic      [LHP_WORD_W-1:0] RX_WORD,
  // Read-back data from the core
  input  wire logic [LHP_DATA_W-1:0] RD_DATA,
  output logic                       RD_TAKEN,
  // Status
  output logic                       IN_RESET,
  output logic                       OVERRUN
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  lhp_pins_s pins_raw;
  lhp_pins_s s1_r;
  lhp_pins_s s2_r;
  lhp_pins_s s3_r;
  lhp_pins_s pin_r;
  logic      res_s1_r;
  logic      res_s2_r;
  logic      res_s3_r;
  logic      res_n_r;

  assign pins_raw = '{par_sel: PAR_SERIAL_STRAP, fam_enclk: HOST_FAMILY_STRAP,
                      cs_low_act: CHIP_SELECT_LOW_ACTIVE_N,
                      cs_high_act: CHIP_SELECT_HIGH_ACTIVE,
                      dc_sel: DATA_COMMAND_SELECT, rd_e: RD_N_E, wr_rw: WR_N_RW,
                      d: D_IN};

  // A change counts once the second and third stages agree.
  function automatic lhp_pins_s settle(lhp_pins_s cur, lhp_pins_s a, lhp_pins_s b);
    lhp_pins_s r;
    r = cur;
    for (int i = 0; i < LHP_PINS_W; i++) begin
      if (a[i] == b[i]) begin
        r[i] = a[i];
      end
    end
    return r;
  endfunction

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else begin
      s1_r  <= pins_raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= settle(pin_r, s2_r, s3_r);
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      res_s1_r <= 1'b0;
      res_s2_r <= 1'b0;
      res_s3_r <= 1'b0;
      res_n_r  <= 1'b0;
    end else begin
      res_s1_r <= RESET_LOW_INPUT_N;
      res_s2_r <= res_s1_r;
      res_s3_r <= res_s2_r;
      if (res_s2_r == res_s3_r) begin
        res_n_r <= res_s2_r;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------------
  lhp_pins_s pin_q;
  logic      port_rst;
  logic      selected;
  logic      par_mode;
  logic      enclk_mode;
  logic      is_data;

  assign port_rst   = SYS_RST || !res_n_r;
  assign selected   = !pin_r.cs_low_act && pin_r.cs_high_act;
  assign par_mode   = pin_r.par_sel;
  assign enclk_mode = pin_r.fam_enclk;
  assign is_data    = pin_r.dc_sel;

  // Follows the settled pins through reset as well, so no false edge shows after it.
  always_ff @(posedge CLK) begin
    pin_q <= pin_r;
  end

  // ---------------------------------------------------------------------------
  // Parallel transfer sequencing
  // ---------------------------------------------------------------------------
  lhp_state_e state_r;
  lhp_state_e state_nxt;
  logic       wr_lead;
  logic       rd_active;
  logic       e_rise;
  logic       e_fall;

  assign e_rise  = pin_r.rd_e && !pin_q.rd_e;
  assign e_fall  = !pin_r.rd_e && pin_q.rd_e;
  assign wr_lead = !pin_r.wr_rw && pin_q.wr_rw;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LHP_IDLE: begin
        if (par_mode && selected) begin
          if (enclk_mode) begin
            if (e_rise) begin
              state_nxt = pin_r.wr_rw ? LHP_READ : LHP_WRITE;
            end
          end else if (!pin_r.rd_e) begin
            state_nxt = LHP_READ;
          end
        end
      end
      LHP_WRITE: begin
        if (e_fall || !selected) begin
          state_nxt = LHP_IDLE;
        end
      end
      LHP_READ: begin
        if (!selected || !par_mode) begin
          state_nxt = LHP_IDLE;
        end else if (enclk_mode ? e_fall : pin_r.rd_e) begin
          state_nxt = LHP_IDLE;
        end
      end
      default: begin
        state_nxt = LHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (port_rst) begin
      state_r <= LHP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Enable-clock writes latch on the falling edge of the enable, strobe writes
  // on the leading edge of the write strobe.
  logic par_wr;
  assign par_wr = par_mode && selected && (enclk_mode ?
                  (state_r == LHP_WRITE && e_fall) : wr_lead);

  // ---------------------------------------------------------------------------
  // Serial receiver
  // ---------------------------------------------------------------------------
  logic [LHP_BIT_CW-1:0] bit_cnt_r;
  logic [LHP_DATA_W-1:0] shift_r;
  logic                  scl_rise;
  logic                  ser_wr;

  assign scl_rise = pin_r.d[LHP_SCL_BIT] && !pin_q.d[LHP_SCL_BIT];
  assign ser_wr   = !par_mode && selected && scl_rise && (bit_cnt_r == LHP_BIT_LAST);

  always_ff @(posedge CLK) begin
    if (port_rst || !selected || par_mode) begin
      bit_cnt_r <= LHP_BIT_ZERO;
      shift_r   <= LHP_BYTE_ZERO;
    end else if (scl_rise) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      shift_r   <= {shift_r[LHP_DATA_W-2:0], pin_r.d[LHP_SI_BIT]};
    end
  end

  // ---------------------------------------------------------------------------
  // Receive FIFO
  // ---------------------------------------------------------------------------
  lhp_word_s in_word;
  logic      in_valid;
  logic      in_ready;
  logic      out_valid;
  logic      [LHP_WORD_W-1:0] out_data;

  assign in_valid = par_wr || ser_wr;
  always_comb begin
    in_word.is_data = is_data;
    in_word.value   = par_mode ? pin_r.d : {shift_r[LHP_DATA_W-2:0], pin_r.d[LHP_SI_BIT]};
  end

  lhp_fifo #(.WIDTH(LHP_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst       (port_rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_word),
    .out_valid (out_valid),
    .out_ready (RX_READY && !RX_VALID),
    .out_data  (out_data)
  );

  // Output stage: one registered word held until the core takes it.
  always_ff @(posedge CLK) begin
    if (port_rst) begin
      RX_VALID <= 1'b0;
      RX_WORD  <= '0;
    end else if (RX_VALID && RX_READY) begin
      RX_VALID <= 1'b0;
    end else if (!RX_VALID && out_valid && RX_READY) begin
      RX_VALID <= 1'b1;
      RX_WORD  <= out_data;
    end
  end

  // The host bus cannot be stalled, so a write into a full FIFO is flagged.
  always_ff @(posedge CLK) begin
    if (port_rst) begin
      OVERRUN <= 1'b0;
    end else if (in_valid && !in_ready) begin
      OVERRUN <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Data pin drive
  // ---------------------------------------------------------------------------
  logic drive;
  assign drive = par_mode && selected && (state_nxt == LHP_READ);

  always_ff @(posedge CLK) begin
    if (port_rst) begin
      D_OE     <= LHP_OE_NONE;
      D_OUT    <= LHP_BYTE_ZERO;
      RD_TAKEN <= 1'b0;
      IN_RESET <= 1'b1;
    end else begin
      D_OE     <= drive ? LHP_OE_ALL : LHP_OE_NONE;
      D_OUT    <= drive ? RD_DATA : LHP_BYTE_ZERO;
      RD_TAKEN <= (state_r == LHP_READ) && (state_nxt == LHP_IDLE) && selected;
      IN_RESET <= 1'b0;
    end
  end

endmodule

/* File: inc/lhp_pkg.sv */
package lhp_pkg;

  // ---------------------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------------------
  localparam int unsigned LHP_DATA_W  = 8;
  localparam int unsigned LHP_FIFO_D  = 16;
  localparam int unsigned LHP_BIT_CW  = 3;
  localparam logic [2:0]  LHP_BIT_LAST = 3'h7;
  localparam logic [2:0]  LHP_BIT_ZERO = 3'h0;
  localparam int unsigned LHP_SI_BIT  = 7;
  localparam int unsigned LHP_SCL_BIT = 6;
  localparam logic [7:0]  LHP_BYTE_ZERO = 8'h00;
  localparam logic [7:0]  LHP_OE_ALL    = 8'hFF;
  localparam logic [7:0]  LHP_OE_NONE   = 8'h00;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } lhp_word_s;

  localparam int unsigned LHP_WORD_W = 9;

  typedef struct packed {
    logic       par_sel;
    logic       fam_enclk;
    logic       cs_low_act;
    logic       cs_high_act;
    logic       dc_sel;
    logic       rd_e;
    logic       wr_rw;
    logic [7:0] d;
  } lhp_pins_s;

  localparam int unsigned LHP_PINS_W = 15;

  typedef enum logic [1:0] {
    LHP_IDLE  = 2'b00,
    LHP_WRITE = 2'b01,
    LHP_READ  = 2'b10
  } lhp_state_e;

endpackage

/* File: hw/lhp_fifo.sv */
`timescale 1ns/1ps
module lhp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: tb/lhp_host_port_assertions.sv */
`timescale 1ns/1ps
module lhp_host_port_chk
  import lhp_pkg::*;
(
  // Clock and resets
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       RESET_LOW_INPUT_N,
  // Pins
  input wire logic       PAR_SERIAL_STRAP,
  input wire logic       HOST_FAMILY_STRAP,
  input wire logic       CHIP_SELECT_LOW_ACTIVE_N,
  input wire logic       CHIP_SELECT_HIGH_ACTIVE,
  input wire logic       RD_N_E,
  input wire logic       WR_N_RW,
  input wire logic [7:0] D_OE,
  // Core side and status
  input wire logic       RX_VALID,
  input wire logic       RX_READY,
  input wire logic [8:0] RX_WORD,
  input wire logic       RD_TAKEN,
  input wire logic       IN_RESET,
  input wire logic       OVERRUN
);
  logic sel;
  logic p_stb;
  logic p_en;
  logic off;
  logic on;
  assign sel   = !CHIP_SELECT_LOW_ACTIVE_N && CHIP_SELECT_HIGH_ACTIVE;
  assign p_stb = PAR_SERIAL_STRAP && !HOST_FAMILY_STRAP;
  assign p_en  = PAR_SERIAL_STRAP && HOST_FAMILY_STRAP;
  assign off   = D_OE == LHP_OE_NONE;
  assign on    = D_OE == LHP_OE_ALL;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_oe_whole: assert property (off || on)
    else $error("data enable split");
  a_idle_released: assert property (!sel [*8] |-> off)
    else $error("driven while deselected");
  a_serial_released: assert property (!PAR_SERIAL_STRAP [*8] |-> off)
    else $error("driven in serial mode");
  a_pin_reset: assert property (!RESET_LOW_INPUT_N [*7] |-> IN_RESET && !RX_VALID && off)
    else $error("pin reset not applied");
  a_strobe_read: assert property ((sel && p_stb && !RD_N_E) [*8] |-> on)
    else $error("read strobe not driving");
  a_strobe_quiet: assert property ((p_stb && RD_N_E) [*8] |-> off)
    else $error("driven without read strobe");
  a_enclk_read: assert property ((sel && p_en && WR_N_RW && RD_N_E) [*8] |-> on)
    else $error("enable read not driving");
  a_enclk_write: assert property ((p_en && !WR_N_RW) [*8] |-> off)
    else $error("driven in write cycle");
  a_rx_hold: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_WORD))
    else $error("word not held");
  a_taken_pulse: assert property (RD_TAKEN |=> !RD_TAKEN)
    else $error("read end not a pulse");
  c_serial_word: cover property (!PAR_SERIAL_STRAP && RX_VALID && RX_READY);
  c_read_done: cover property (RD_TAKEN);
  c_overrun: cover property ($rose(OVERRUN));
endmodule

bind lhp_host_port lhp_host_port_chk u_chk (
  .CLK, .SYS_RST, .RESET_LOW_INPUT_N, .PAR_SERIAL_STRAP, .HOST_FAMILY_STRAP,
  .CHIP_SELECT_LOW_ACTIVE_N, .CHIP_SELECT_HIGH_ACTIVE, .RD_N_E, .WR_N_RW, .D_OE,
  .RX_VALID, .RX_READY, .RX_WORD, .RD_TAKEN, .IN_RESET, .OVERRUN
);

/* File: tb/lhp_host_model.sv */
`timescale 1ns/1ps
module lhp_host_model
  import lhp_pkg::*;
(
  // Clock and wire level
  input  wire logic       clk,
  input  wire logic [7:0] bus,
  // Host pins
  output lhp_pins_s       p,
  output logic      [7:0] d_host
);
  logic       drv = 1'b0;
  logic       ser = 1'b0;
  logic [7:0] pat = 8'h5A;
  initial p = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
  // Released lines show a value that changes every cycle.
  always @(posedge clk) pat <= pat + 8'h35;
  assign d_host = drv ? p.d : (ser ? {p.d[7:6], pat[5:0]} : pat);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic mode(input logic ps, input logic fm);
    p.par_sel   = ps;
    p.fam_enclk = fm;
    p.rd_e      = !fm;
    p.wr_rw     = !fm;
    p.d         = 8'h00;
    ser         = !ps;
    cyc(12);
  endtask
  task automatic csel(input logic lo, input logic hi);
    p.cs_low_act  = lo;
    p.cs_high_act = hi;
  endtask
  task automatic wr(input logic dc, input logic [7:0] b);
    p.dc_sel = dc;
    p.d      = b;
    drv      = 1'b1;
    cyc(6);
    if (p.fam_enclk) p.rd_e = 1'b1;
    else p.wr_rw = 1'b0;
    cyc(8);
    if (p.fam_enclk) p.rd_e = 1'b0;
    else p.wr_rw = 1'b1;
    cyc(6);
    drv = 1'b0;
  endtask
  task automatic rd(output logic [7:0] b);
    p.wr_rw = 1'b1;
    cyc(6);
    p.rd_e = p.fam_enclk;
    cyc(10);
    b      = bus;
    p.rd_e = !p.fam_enclk;
    cyc(8);
    p.wr_rw = !p.fam_enclk;
    cyc(2);
  endtask
  task automatic sbyte(input logic dc, input logic [7:0] b, input int n);
    p.dc_sel = dc;
    for (int i = 0; i < n; i++) begin
      p.d[7] = b[7-i];
      cyc(4);
      p.d[6] = 1'b1;
      cyc(4);
      p.d[6] = 1'b0;
    end
    cyc(6);
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb
  import lhp_pkg::*;
;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        RESET_LOW_INPUT_N = 1'b1;
  logic        RX_READY = 1'b0;
  logic [7:0]  RD_DATA = 8'h00;
  logic [7:0]  D_OUT, D_OE, host_d;
  logic        RX_VALID, RD_TAKEN, IN_RESET, OVERRUN;
  logic [8:0]  RX_WORD;
  lhp_pins_s   p;
  wire  [7:0]  D_IN = (D_OE & D_OUT) | (~D_OE & host_d);
  logic [15:0] lf = 16'hBC08;
  logic        stall = 1'b0;
  logic        ovf = 1'b0;
  int          errors = 0;
  int          num_checks = 0;
  int          drained = 0;
  int          taken = 0;
  int          cycles = 0;
  lhp_word_s   q[$];
  lhp_host_port uut (
    .CLK, .SYS_RST, .RESET_LOW_INPUT_N, .D_IN, .D_OUT, .D_OE, .RX_VALID, .RX_READY,
    .RX_WORD, .RD_DATA, .RD_TAKEN, .IN_RESET, .OVERRUN,
    .PAR_SERIAL_STRAP(p.par_sel), .HOST_FAMILY_STRAP(p.fam_enclk),
    .CHIP_SELECT_LOW_ACTIVE_N(p.cs_low_act), .CHIP_SELECT_HIGH_ACTIVE(p.cs_high_act),
    .DATA_COMMAND_SELECT(p.dc_sel), .RD_N_E(p.rd_e), .WR_N_RW(p.wr_rw)
  );
  lhp_host_model host (.clk(CLK), .bus(D_IN), .p(p), .d_host(host_d));
  initial forever #20 CLK = ~CLK;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    chk_word({1'b0, got}, {1'b0, exp});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge CLK) begin
    #1;
    lf = lfsr(lf);
    RX_READY = !stall && lf[0];
  end
  always @(posedge CLK) begin
    cycles++;
    if (RD_TAKEN) taken++;
    if (cycles == 12000) begin
      errors++;
      close_out;
    end else if (RX_VALID && RX_READY) begin
      if (ovf) drained++;
      else if (q.size() == 0) chk_word(RX_WORD, ~RX_WORD);
      else chk_word(RX_WORD, q.pop_front());
    end
  end
  initial begin
    logic [7:0] b;
    logic [7:0] r;
    repeat (4) @(posedge CLK);
    #1 SYS_RST = 1'b0;
    for (int m = 0; m < 2; m++) begin
      host.mode(1'b1, m[0]);
      for (int k = 0; k < 4; k++) begin
        b = lf[15:8];
        q.push_back({k[0], b});
        host.wr(k[0], b);
      end
      RD_DATA = lf[7:0];
      host.rd(r);
      chk_val(r, RD_DATA);
      chk_val(D_OE, LHP_OE_NONE);
      chk_val(8'(taken), 8'(m + 1));
      $display("parallel test %0d done", m);
    end
    host.csel(1'b0, 1'b0);
    host.wr(1'b1, 8'hA5);
    host.csel(1'b1, 1'b1);
    host.wr(1'b0, 8'h5A);
    host.csel(1'b1, 1'b0);
    host.wr(1'b1, lf[15:8]);
    host.csel(1'b0, 1'b1);
    chk_val(q.size(), 8'h00);
    $display("deselect test done");
    host.mode(1'b0, 1'b0);
    host.p.rd_e = 1'b0;
    host.sbyte(1'b1, 8'hFF, 5);
    host.csel(1'b1, 1'b1);
    host.cyc(8);
    host.csel(1'b0, 1'b1);
    host.cyc(8);
    for (int k = 0; k < 4; k++) begin
      b = lf[15:8];
      q.push_back({k[1], b});
      host.sbyte(k[1], b, 8);
    end
    host.cyc(30);
    chk_val(q.size(), 8'h00);
    chk_val(D_OE, LHP_OE_NONE);
    $display("serial test done");
    host.mode(1'b1, 1'b0);
    stall = 1'b1;
    ovf   = 1'b1;
    repeat (LHP_FIFO_D + 4) host.wr(1'b1, lf[15:8]);
    chk_val({7'h00, OVERRUN}, 8'h01);
    stall = 1'b0;
    host.cyc(200);
    chk_val({7'h00, drained == LHP_FIFO_D}, 8'h01);
    chk_val({7'h00, RX_VALID}, 8'h00);
    ovf     = 1'b0;
    SYS_RST = 1'b1;
    host.cyc(2);
    SYS_RST = 1'b0;
    host.cyc(14);
    chk_val({7'h00, OVERRUN}, 8'h00);
    $display("fill test done");
    RESET_LOW_INPUT_N = 1'b0;
    host.cyc(10);
    chk_val({6'h00, IN_RESET, RX_VALID}, 8'h02);
    RESET_LOW_INPUT_N = 1'b1;
    host.cyc(14);
    q.push_back({1'b0, 8'h3C});
    host.wr(1'b0, 8'h3C);
    host.cyc(40);
    chk_val(q.size(), 8'h00);
    $display("reset test done");
    close_out;
  end
endmodule
